// >>> verilog/rspc_pkg.sv
// shared constants and types of the rs-485 serial port with apb registers
`default_nettype none
package rspc_pkg;

   // register byte offsets
   localparam logic [7:0] RSPC_OFF_CFG    = 8'h00;
   localparam logic [7:0] RSPC_OFF_STATUS = 8'h04;
   localparam logic [7:0] RSPC_OFF_MASK   = 8'h08;
   localparam logic [7:0] RSPC_OFF_RXDATA = 8'h0C;
   localparam logic [7:0] RSPC_OFF_TXDATA = 8'h10;
   localparam logic [7:0] RSPC_OFF_LINE   = 8'h14;

   // status / mask bit positions
   localparam int RSPC_EV_RX_DONE = 0;
   localparam int RSPC_EV_PAR_ERR = 1;
   localparam int RSPC_EV_STP_ERR = 2;
   localparam int RSPC_EV_TX_DONE = 3;
   localparam int RSPC_EV_W       = 4;

   // station address limit
   localparam logic [7:0] RSPC_STATION_MAX = 8'h80;

   // default internal clock rate in hz
   localparam int RSPC_CLK_HZ = 200000000;

   typedef enum logic [2:0] {
      RSPC_RATE_76800 = 3'h0,
      RSPC_RATE_38400 = 3'h1,
      RSPC_RATE_19200 = 3'h2,
      RSPC_RATE_9600  = 3'h3,
      RSPC_RATE_4800  = 3'h4
   } rspc_rate_t;

   typedef enum logic [1:0] {
      RSPC_PAR_NONE = 2'h0,
      RSPC_PAR_ODD  = 2'h1,
      RSPC_PAR_EVEN = 2'h2
   } rspc_par_t;

   // configuration word, bit 15 down to bit 0
   typedef struct packed {
      logic       err_disp_en;   // bit 15
      logic       stop_two;      // bit 14
      rspc_par_t  parity;        // bits 13:12
      logic       len_seven;     // bit 11
      rspc_rate_t rate;          // bits 10:8
      logic [7:0] station;       // bits 7:0
   } rspc_cfg_t;

   localparam rspc_cfg_t RSPC_CFG_RESET = '{
      err_disp_en : 1'b0,
      stop_two    : 1'b0,
      parity      : RSPC_PAR_EVEN,
      len_seven   : 1'b0,
      rate        : RSPC_RATE_38400,
      station     : 8'h00
   };

   typedef enum logic [2:0] {
      RSPC_LN_IDLE  = 3'h0,
      RSPC_LN_START = 3'h1,
      RSPC_LN_DATA  = 3'h2,
      RSPC_LN_PAR   = 3'h3,
      RSPC_LN_STOP  = 3'h4
   } rspc_line_t;

   // one serial direction: shared by receiver and transmitter
   typedef struct packed {
      rspc_line_t  st;
      logic [15:0] cnt;
      logic [2:0]  bitn;
      logic [7:0]  sh;
      logic        par;
      logic        stop_seen;
   } rspc_ser_t;

   // bits per second for each rate code
   function automatic int rspc_baud(input rspc_rate_t r);
      case (r)
         RSPC_RATE_76800: rspc_baud = 76800;
         RSPC_RATE_19200: rspc_baud = 19200;
         RSPC_RATE_9600:  rspc_baud = 9600;
         RSPC_RATE_4800:  rspc_baud = 4800;
         default:         rspc_baud = 38400;
      endcase
   endfunction

endpackage
`default_nettype wire

// >>> verilog/rspc_serial_port.sv
// rs-485 serial port: apb registers, configurable framing, rx checks, interrupt
//
// Notes on behaviour
// R1: the station address is kept in the range 0 to 128 and resets to 0.
// R2: the port runs at 76800, 38400, 19200, 9600 or 4800 bit/s, matched by the host.
// R3: with no other rate chosen the port runs at 38400 bit/s.
// R4: characters carry seven or eight data bits, eight by default, matched by the host.
// R5: framing uses odd, even or no parity, even by default, matched by the host.
// R6: characters end with one or two stop bits, one by default, matched by the host.
// R7: an on/off setting, off by default, gates showing communication errors.
// R8: the receiver flags parity and stop-bit errors and drives the display only when enabled.
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module rspc_serial_port
   import rspc_pkg::*;
#(
   parameter int CLK_HZ = RSPC_CLK_HZ
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // rs-485 line
   input  wire logic        rxd,
   output logic             txd,
   output logic             tx_drive_en,
   // indicators
   output logic             comm_err_display,
   output logic             irq
);
   import rspc_pkg::*;

   typedef struct packed {
      rspc_cfg_t              cfg;
      logic [RSPC_EV_W-1:0]   status;
      logic [RSPC_EV_W-1:0]   mask;
      logic [7:0]             rx_data;
      logic [31:0]            rdata;
      rspc_ser_t              rx;
      rspc_ser_t              tx;
      logic                   txd;
   } rspc_state_t;

   rspc_state_t s;
   rspc_state_t next_s;

   // address decode, used by write path and error answer
   function automatic logic rspc_mapped(input logic [7:0] a);
      rspc_mapped = (a == RSPC_OFF_CFG) || (a == RSPC_OFF_STATUS) ||
                    (a == RSPC_OFF_MASK) || (a == RSPC_OFF_RXDATA) ||
                    (a == RSPC_OFF_TXDATA) || (a == RSPC_OFF_LINE);
   endfunction

   // bit period in clocks for the selected rate; truncation error is under 0.01 %
   logic [15:0] div;
   logic [15:0] half;
   logic [2:0]  last_bit;
   logic        wr;
   logic        rx_tick;
   logic        tx_tick;
   logic [RSPC_EV_W-1:0] ev_set;
   logic [RSPC_EV_W-1:0] ev_clr;
   rspc_cfg_t   wcfg;

   assign div      = 16'(CLK_HZ / rspc_baud(s.cfg.rate)); // R2 R3
   assign half     = {1'b0, div[15:1]};
   assign last_bit = s.cfg.len_seven ? 3'h6 : 3'h7; // R4
   assign wr       = psel && penable && pwrite;
   assign rx_tick  = (s.rx.cnt == 16'h0000);
   assign tx_tick  = (s.tx.cnt == 16'h0000);
   assign wcfg     = rspc_cfg_t'(pwdata[15:0]);

   always_comb begin
      next_s = s;
      ev_set = '0;
      ev_clr = '0;

      // read data is latched in the setup phase so it comes from a flip-flop
      if (psel && !penable) begin
         next_s.rdata = 32'h0000_0000;
         case (paddr)
            RSPC_OFF_CFG:    next_s.rdata = {16'h0000, s.cfg};
            RSPC_OFF_STATUS: next_s.rdata = {28'h000_0000, s.status};
            RSPC_OFF_MASK:   next_s.rdata = {28'h000_0000, s.mask};
            RSPC_OFF_RXDATA: next_s.rdata = {24'h00_0000, s.rx_data};
            RSPC_OFF_LINE:   next_s.rdata = {30'h0000_0000, s.rx.st != RSPC_LN_IDLE,
                                             s.tx.st != RSPC_LN_IDLE};
            default:         next_s.rdata = 32'h0000_0000;
         endcase
      end

      // register writes; illegal field codes keep the old setting
      if (wr && rspc_mapped(paddr)) begin
         case (paddr)
            RSPC_OFF_CFG: begin
               if (wcfg.station <= RSPC_STATION_MAX) begin
                  next_s.cfg.station = wcfg.station; // R1
               end
               if (wcfg.rate <= RSPC_RATE_4800) begin
                  next_s.cfg.rate = wcfg.rate; // R2
               end
               next_s.cfg.len_seven = wcfg.len_seven; // R4
               if (wcfg.parity != 2'h3) begin
                  next_s.cfg.parity = wcfg.parity; // R5
               end
               next_s.cfg.stop_two    = wcfg.stop_two; // R6
               next_s.cfg.err_disp_en = wcfg.err_disp_en; // R7
            end
            RSPC_OFF_STATUS: ev_clr = pwdata[RSPC_EV_W-1:0];
            RSPC_OFF_MASK:   next_s.mask = pwdata[RSPC_EV_W-1:0];
            default: begin
            end
         endcase
      end

      // receiver: start bit checked at mid-bit, later bits sampled one period apart
      next_s.rx.cnt = rx_tick ? div - 16'h0001 : s.rx.cnt - 16'h0001;
      unique case (s.rx.st)
         RSPC_LN_IDLE: begin
            next_s.rx.cnt = half;
            if (!rxd) begin
               next_s.rx.st = RSPC_LN_START;
            end
         end
         RSPC_LN_START: begin
            if (rx_tick) begin
               // a short low glitch is not a start bit
               next_s.rx.st   = rxd ? RSPC_LN_IDLE : RSPC_LN_DATA;
               next_s.rx.bitn = 3'h0;
               next_s.rx.par  = 1'b0;
            end
         end
         RSPC_LN_DATA: begin
            if (rx_tick) begin
               next_s.rx.sh   = {rxd, s.rx.sh[7:1]};
               next_s.rx.par  = s.rx.par ^ rxd;
               next_s.rx.bitn = s.rx.bitn + 3'h1;
               if (s.rx.bitn == last_bit) begin // R4
                  next_s.rx.st        = (s.cfg.parity == RSPC_PAR_NONE) ?
                                        RSPC_LN_STOP : RSPC_LN_PAR; // R5
                  next_s.rx.stop_seen = 1'b0;
               end
            end
         end
         RSPC_LN_PAR: begin
            if (rx_tick) begin
               // even: data plus parity bit has an even count of ones
               if ((s.rx.par ^ rxd) != (s.cfg.parity == RSPC_PAR_ODD)) begin
                  ev_set[RSPC_EV_PAR_ERR] = 1'b1; // R5 R8
               end
               next_s.rx.st        = RSPC_LN_STOP;
               next_s.rx.stop_seen = 1'b0;
            end
         end
         RSPC_LN_STOP: begin
            if (rx_tick) begin
               if (!rxd) begin
                  ev_set[RSPC_EV_STP_ERR] = 1'b1; // R8
               end
               if (s.cfg.stop_two && !s.rx.stop_seen) begin
                  next_s.rx.stop_seen = 1'b1; // R6
               end else begin
                  next_s.rx.st = RSPC_LN_IDLE;
                  next_s.rx_data = s.cfg.len_seven ? {1'b0, s.rx.sh[7:1]} : s.rx.sh;
                  ev_set[RSPC_EV_RX_DONE] = 1'b1;
               end
            end
         end
         default: next_s.rx.st = RSPC_LN_IDLE;
      endcase

      // transmitter: a write to txdata while busy is dropped
      next_s.tx.cnt = tx_tick ? div - 16'h0001 : s.tx.cnt - 16'h0001;
      unique case (s.tx.st)
         RSPC_LN_IDLE: begin
            next_s.txd    = 1'b1;
            next_s.tx.cnt = div - 16'h0001;
            if (wr && (paddr == RSPC_OFF_TXDATA)) begin
               next_s.tx.st = RSPC_LN_START;
               next_s.tx.sh = pwdata[7:0];
               next_s.txd   = 1'b0;
            end
         end
         RSPC_LN_START: begin
            if (tx_tick) begin
               next_s.txd     = s.tx.sh[0];
               next_s.tx.par  = s.tx.sh[0];
               next_s.tx.sh   = {1'b0, s.tx.sh[7:1]};
               next_s.tx.bitn = 3'h0;
               next_s.tx.st   = RSPC_LN_DATA;
            end
         end
         RSPC_LN_DATA: begin
            if (tx_tick) begin
               next_s.tx.bitn = s.tx.bitn + 3'h1;
               next_s.tx.stop_seen = 1'b0;
               if (s.tx.bitn == last_bit) begin // R4
                  if (s.cfg.parity == RSPC_PAR_NONE) begin
                     next_s.txd   = 1'b1;
                     next_s.tx.st = RSPC_LN_STOP;
                  end else begin
                     next_s.txd   = s.tx.par ^ (s.cfg.parity == RSPC_PAR_ODD); // R5
                     next_s.tx.st = RSPC_LN_PAR;
                  end
               end else begin
                  next_s.txd    = s.tx.sh[0];
                  next_s.tx.par = s.tx.par ^ s.tx.sh[0];
                  next_s.tx.sh  = {1'b0, s.tx.sh[7:1]};
               end
            end
         end
         RSPC_LN_PAR: begin
            if (tx_tick) begin
               next_s.txd   = 1'b1;
               next_s.tx.st = RSPC_LN_STOP;
            end
         end
         RSPC_LN_STOP: begin
            if (tx_tick) begin
               if (s.cfg.stop_two && !s.tx.stop_seen) begin
                  next_s.tx.stop_seen = 1'b1; // R6
               end else begin
                  next_s.tx.st = RSPC_LN_IDLE;
                  ev_set[RSPC_EV_TX_DONE] = 1'b1;
               end
            end
         end
         default: next_s.tx.st = RSPC_LN_IDLE;
      endcase

      // sticky events: a new event wins over a write-one clear in the same cycle
      next_s.status = (s.status & ~ev_clr) | ev_set;
   end

   // single state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s         <= '0;
         s.cfg     <= RSPC_CFG_RESET; // R1 R3 R4 R5 R6 R7
         s.txd     <= 1'b1;
         s.rx.st   <= RSPC_LN_IDLE;
         s.tx.st   <= RSPC_LN_IDLE;
      end else begin
         s <= next_s;
      end
   end

   // outputs
   assign prdata      = s.rdata;
   assign pready      = 1'b1; // zero wait states
   assign pslverr     = psel && penable && !rspc_mapped(paddr);
   assign txd         = s.txd;
   assign tx_drive_en = (s.tx.st != RSPC_LN_IDLE);
   assign irq         = |(s.status & s.mask);
   // error display follows the sticky error bits, gated by the enable
   assign comm_err_display = s.cfg.err_disp_en &&
                             (s.status[RSPC_EV_PAR_ERR] || s.status[RSPC_EV_STP_ERR]); // R7 R8

endmodule
`default_nettype wire

// >>> testbench/rspc_serial_port_properties.sv
// concurrent checks of the rs-485 serial port
`timescale 1ns/10ps
`default_nettype none
module rspc_serial_port_properties
   import rspc_pkg::*;
#(
   parameter int CLK_HZ = RSPC_CLK_HZ
) (
   // clock, reset and apb
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   // line and display
   input wire logic        txd,
   input wire logic        tx_drive_en,
   input wire logic        comm_err_display
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic wr;
   logic en;
   wire  rd = psel && penable && !pwrite && paddr == RSPC_OFF_CFG;
   // shadow of cfg writes: defaults are only judged before the first one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr <= 1'b0;
         en <= 1'b0;
      end else if (psel && penable && pwrite && paddr == RSPC_OFF_CFG) begin
         wr <= 1'b1;
         en <= pwdata[15];
      end
   end
   // a frame opens with a start bit low for at least two whole cycles
   sequence s_start;
      !txd [*2];
   endsequence
   chk_station_range: assert property (rd |-> prdata[7:0] <= RSPC_STATION_MAX) else $error("addr");
   chk_rate_code: assert property (rd |-> prdata[10:8] <= 3'h4) else $error("rate");
   chk_rate_default: assert property (rd && !wr |-> prdata[10:8] == 3'h1) else $error("rate");
   chk_len_default: assert property (rd && !wr |-> !prdata[11]) else $error("length");
   chk_parity_mode: assert property (rd |-> prdata[13:12] != 2'h3 && (wr || prdata[13]))
      else $error("parity");
   chk_stop_default: assert property (rd && !wr |-> !prdata[14]) else $error("stops");
   chk_disp_default: assert property (rd && !wr |-> !prdata[15]) else $error("display");
   chk_disp_gated: assert property (comm_err_display |-> en) else $error("display");
   chk_line_idle: assert property (!tx_drive_en |-> txd) else $error("idle");
   chk_start_bit: assert property ($rose(tx_drive_en) |-> s_start) else $error("start");
endmodule
bind rspc_serial_port rspc_serial_port_properties #(.CLK_HZ(CLK_HZ)) chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .txd(txd), .tx_drive_en(tx_drive_en),
   .comm_err_display(comm_err_display));
`default_nettype wire

// >>> testbench/rspc_host.sv
// host-side model of the far end of the rs-485 line
`timescale 1ns/10ps
`default_nettype none
module rspc_host (
   // clock and line
   input  wire logic pclk,
   input  wire logic line_in,
   output logic      line_out
);
   initial line_out = 1'b1;
   // parity of the low n bits: code 1 odd, 2 even, else none
   function automatic logic par(input logic [7:0] d, input int n, input logic [1:0] m);
      logic x;
      x = ^(n == 7 ? {1'b0, d[6:0]} : d);
      return m == 2'h1 ? !x : (m == 2'h2 ? x : 1'b0);
   endfunction
   task automatic put(input logic b, input int div);
      line_out <= b;
      repeat (div) @(posedge pclk);
   endtask
   // one frame lsb first; bp and bs break parity or stop on purpose
   task automatic send(input logic [7:0] d, input int div, n, st, input logic [1:0] m,
                       input logic bp, bs);
      put(1'b0, div);
      for (int i = 0; i < n; i++) put(d[i], div);
      if (m != 2'h0) put(par(d, n, m) ^ bp, div);
      for (int i = 0; i < st; i++) put(!bs, div);
      line_out <= 1'b1;
   endtask
   // one frame from the port, sampled mid-bit; ok drops on a bad start or stop
   task automatic recv(input int div, n, st, input logic [1:0] m,
                       output logic [7:0] d, output logic p, ok);
      d = 8'h00;
      p = 1'b0;
      for (int w = 0; w < 5000 && line_in === 1'b1; w++) @(posedge pclk);
      repeat (div / 2) @(posedge pclk);
      ok = line_in === 1'b0;
      for (int i = 0; i < n + (m != 2'h0) + st; i++) begin
         repeat (div) @(posedge pclk);
         if (i < n) d[i] = line_in;
         else if (i == n && m != 2'h0) p = line_in;
         else ok &= line_in === 1'b1;
      end
   endtask
endmodule
`default_nettype wire

// >>> testbench/test_rspc_serial_port.sv
// self-checking bench of the rs-485 serial port
`timescale 1ns/10ps
`default_nettype none
module test_rspc_serial_port;
   import rspc_pkg::*;
   // shortened clock figure: bit periods of 10 to 160 cycles
   localparam int CLK_HZ = 768000;
   localparam int BAUD[5] = '{76800, 38400, 19200, 9600, 4800};
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, rxd, txd, tx_drive_en, comm_err_display, irq, err;
   int          miscompares = 0, total_checks = 0;
   rspc_serial_port #(.CLK_HZ(CLK_HZ)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rxd(rxd), .txd(txd), .tx_drive_en(tx_drive_en),
      .comm_err_display(comm_err_display), .irq(irq));
   rspc_host host (.pclk(pclk), .line_in(txd), .line_out(rxd));
   task automatic conclude();
      if (miscompares == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic expire();
      miscompares++;
      conclude();
   endtask
   task automatic check(input logic [31:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   // one apb transfer, entered right after an edge; an idle edge follows
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) expire();
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // poll status until bit b is set, bounded so a hang ends the run
   task automatic wait_st(input int b);
      int k;
      k = 0;
      do begin
         apb(1'b0, RSPC_OFF_STATUS, 32'h0);
         k++;
      end while (rd[b] !== 1'b1 && k < 2000);
      if (k >= 2000) expire();
   endtask
   function automatic logic [7:0] msk(input logic [7:0] d, input int n);
      return n == 7 ? {1'b0, d[6:0]} : d;
   endfunction
   initial begin
      forever #2.5 pclk = ~pclk;
   end
   // defaults, refused fields, each rate with random framing both ways, error flags
   initial begin
      logic [7:0]  d, got;
      logic [15:0] c;
      logic        p, ok;
      int          n, m, st, dv;
      void'($urandom(32'h1911ECEE));
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, RSPC_OFF_CFG, 32'h0);
      check(rd, 32'h00002100);
      apb(1'b1, RSPC_OFF_CFG, 32'h00003581);
      apb(1'b0, RSPC_OFF_CFG, 32'h0);
      check(rd, 32'h00002100);
      apb(1'b0, 8'h18, 32'h0);
      check({err, rd[30:0]}, 32'h80000000);
      for (int r = 0; r < 5; r++) begin
         n = 7 + $urandom_range(1);
         m = $urandom_range(2);
         st = 1 + $urandom_range(1);
         dv = CLK_HZ / BAUD[r];
         d = r == 0 ? 8'hFF : 8'($urandom);
         c = {1'b0, st == 2, 2'(m), n == 7, 3'(r), r == 4 ? 8'h80 : 8'($urandom_range(128))};
         apb(1'b1, RSPC_OFF_CFG, {16'h0, c});
         apb(1'b0, RSPC_OFF_CFG, 32'h0);
         check(rd, {16'h0, c});
         apb(1'b1, RSPC_OFF_STATUS, 32'h0000000F);
         host.send(d, dv, n, st, 2'(m), 1'b0, 1'b0);
         wait_st(0);
         check(rd[3:0], 4'h1);
         apb(1'b0, RSPC_OFF_RXDATA, 32'h0);
         check(rd, msk(d, n));
         apb(1'b1, RSPC_OFF_TXDATA, {24'h0, d});
         host.recv(dv, n, st, 2'(m), got, p, ok);
         check({ok, p, got}, {1'b1, host.par(d, n, 2'(m)), msk(d, n)});
         wait_st(3);
         check({tx_drive_en, txd}, 2'b01);
         apb(1'b0, RSPC_OFF_LINE, 32'h0);
         check(rd, 32'h00000000);
      end
      // parity then stop faults: display gated by its enable, irq by the mask
      apb(1'b1, RSPC_OFF_CFG, 32'h00001005);
      apb(1'b1, RSPC_OFF_STATUS, 32'h0000000F);
      apb(1'b1, RSPC_OFF_MASK, 32'h00000002);
      apb(1'b0, RSPC_OFF_MASK, 32'h0);
      check(rd, 32'h00000002);
      host.send(8'h3C, 10, 8, 1, 2'h1, 1'b1, 1'b0);
      wait_st(0);
      check({rd[3:0], comm_err_display, irq}, 6'h0D);
      apb(1'b1, RSPC_OFF_CFG, 32'h00009005);
      check(comm_err_display, 1'b1);
      apb(1'b1, RSPC_OFF_STATUS, 32'h00000002);
      check({comm_err_display, irq}, 2'b00);
      host.send(8'hA5, 10, 8, 1, 2'h1, 1'b0, 1'b1);
      wait_st(0);
      check({rd[3:0], comm_err_display, irq}, 6'h16);
      conclude();
   end
endmodule
`default_nettype wire
